//--- core/low_power_mode_wake_control.sv
// Summary of operation
// - Sleep command turns off LIN transceiver, regulator and all switches.
// - In Sleep, monitor pin change or LIN wake enters Standby, regulator on.
// - Watchdog kept on in Sleep: expiry issues reset and enters Standby.
// - LIN wake from Sleep drives receive and data-out low; receive until a mode change command.
// - Watchdog off in Sleep restarts with long open window on wake; off in Stop, on leaving Stop.
// - Sleep with watchdog kept on keeps the oscillator running.
// - Stop command turns off transceiver and termination, regulator stays on.
// - In Stop, monitor pin change pulses data-out low.
// - In Stop, LIN wake holds receive low, data-out low two internal cycles.
// - In Stop, low load current disables watchdog unless keep bit set.
// - Cyclic Stop pulses data-out low two cycles every configured period.
// - Cyclic Stop wake holds data-out low until next valid command.
// - Wake detection works at any point of the cyclic period count.
// - Leaving cyclic Stop restarts watchdog with long open window.
// - Transmit low past dominant timeout is ignored, bus goes recessive.
// - Transmit resumes only after input high for the recovery time.
// - Low slope option selects reduced LIN slew rate.
// - A configuration bit picks battery or temperature measurement channel.
// - Mode pattern 100 selects Sleep and 111 selects Stop.
// - Control bit 15 keeps watchdog on in Stop or Sleep; always on otherwise.
// - Standby is entered only by reset, wake or watchdog expiry in Sleep, never by command.
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "low_power_mode_wake_control_regs.svh"

module low_power_mode_wake_control
    import low_power_mode_wake_control_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        srst,
    input  wire logic [1:0]  addr,
    input  wire logic [15:0] wrData,
    input  wire logic        wrStrobe,
    input  wire logic        rdStrobe,
    output logic      [15:0] rdData,
    input  wire pins_type    pinIn,
    output logic             regulatorEn,
    output logic             linTxEn,
    output logic             linTermEn,
    output logic             switchEn,
    output logic             oscEn,
    output logic             wdEn,
    output logic             wdRestart,
    output logic             resetReq,
    output logic             rxdLine,
    output logic             mcu_interrupt_input,
    output logic             linTxd,
    output logic             lowSlope,
    output logic             measSel
);

    function automatic logic isMode(input logic [2:0] pat);
        isMode = (pat == `PAT_ACTIVE) || (pat == `PAT_ACT_LINOFF) ||
                 (pat == `PAT_SLEEP) || (pat == `PAT_RX_ONLY) ||
                 (pat == `PAT_STOP);
    endfunction : isMode

    function automatic mode_type decodeMode(input logic [2:0] pat);
        case (pat)
            `PAT_ACTIVE:     decodeMode = ACTIVE;
            `PAT_ACT_LINOFF: decodeMode = ACT_LINOFF;
            `PAT_SLEEP:      decodeMode = SLEEP;
            `PAT_RX_ONLY:    decodeMode = RX_ONLY;
            `PAT_STOP:       decodeMode = STOP;
            default:         decodeMode = STANDBY;
        endcase
    endfunction : decodeMode

    // Pin synchronisers; the second and third stages feed logic
    pins_type pinMeta_ff, pinSync_ff, pinPrev_ff;
    always_ff @(posedge sys_clk) begin
        pinMeta_ff <= pinIn;
        pinSync_ff <= pinMeta_ff;
        pinPrev_ff <= pinSync_ff;
    end

    logic tick, monChg, linRise, cmdValid;
    assign tick    = pinSync_ff.oscClk & ~pinPrev_ff.oscClk;
    assign monChg  = |(pinSync_ff.monitor_wake_inputs ^
                       pinPrev_ff.monitor_wake_inputs);
    assign linRise = pinSync_ff.linWake & ~pinPrev_ff.linWake;
    assign cmdValid = wrStrobe && (addr == `CTRL_OFS) &&
                      isMode(wrData[`MODE_LSB +: 3]);

    // Register port
    logic [15:0] ctrl_ff, nxt_ctrl;
    logic [15:0] cfg_ff, nxt_cfg;
    logic [15:0] rdData_ff, nxt_rdData;
    logic        lowSlope_ff, nxt_lowSlope;
    logic        measSel_ff, nxt_measSel;
    mode_type    mode_ff, nxt_mode;
    logic        cyclic_ff, nxt_cyclic;
    logic        wdKeep_ff, nxt_wdKeep;
    logic        wdOff_ff, nxt_wdOff;
    logic        rxdLow_ff, nxt_rxdLow;
    logic        doHold_ff, nxt_doHold;
    logic [1:0]  doCnt_ff, nxt_doCnt;
    logic [7:0]  perCnt_ff, nxt_perCnt;

    always_comb begin
        nxt_ctrl     = ctrl_ff;
        nxt_cfg      = cfg_ff;
        nxt_rdData   = 16'h0000;
        if (cmdValid)
            nxt_ctrl = wrData;
        if (wrStrobe && addr == `CFG_OFS)
            nxt_cfg = wrData;
        if (rdStrobe) begin
            case (addr)
                `CTRL_OFS: nxt_rdData = ctrl_ff;
                `CFG_OFS:  nxt_rdData = cfg_ff;
                `STAT_OFS: nxt_rdData = {8'h00, doHold_ff, rxdLow_ff,
                                         wdOff_ff, cyclic_ff, wdKeep_ff,
                                         mode_ff};
                default:   nxt_rdData = 16'h0000;
            endcase
        end
        nxt_lowSlope = nxt_cfg[`CFG_SLOPE_BIT];
        nxt_measSel  = nxt_cfg[`CFG_MEAS_BIT];
    end
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ctrl_ff     <= `CTRL_RST;
            cfg_ff      <= `CFG_RST;
            rdData_ff   <= 16'h0000;
            lowSlope_ff <= 1'b0;
            measSel_ff  <= 1'b0;
        end else begin
            ctrl_ff     <= nxt_ctrl;
            cfg_ff      <= nxt_cfg;
            rdData_ff   <= nxt_rdData;
            lowSlope_ff <= nxt_lowSlope;
            measSel_ff  <= nxt_measSel;
        end
    end

    // Mode sequencing, wake handling and power switches
    logic regEn_ff, nxt_regEn;
    logic txEn_ff, nxt_txEn;
    logic termEn_ff, nxt_termEn;
    logic swEn_ff, nxt_swEn;
    logic oscEn_ff, nxt_oscEn;
    logic wdEn_ff, nxt_wdEn;
    logic wdRestart_ff, nxt_wdRestart;
    logic resetReq_ff, nxt_resetReq;
    logic rxd_ff, nxt_rxd;
    logic doLine_ff, nxt_doLine;

    always_comb begin
        nxt_mode      = mode_ff;
        nxt_cyclic    = cyclic_ff;
        nxt_wdKeep    = wdKeep_ff;
        nxt_wdOff     = wdOff_ff;
        nxt_rxdLow    = rxdLow_ff;
        nxt_doHold    = doHold_ff;
        nxt_doCnt     = doCnt_ff;
        nxt_perCnt    = perCnt_ff;
        nxt_wdRestart = 1'b0;
        nxt_resetReq  = 1'b0;
        if (tick && doCnt_ff != 2'h0)
            nxt_doCnt = 2'(doCnt_ff - 2'h1);
        // A command clears the held low, yet a same-cycle wake re-arms it
        if (cmdValid) begin
            nxt_doHold = (mode_ff == STOP) && cyclic_ff &&
                         (monChg || linRise);
            if (decodeMode(wrData[`MODE_LSB +: 3]) != mode_ff) begin
                nxt_mode   = decodeMode(wrData[`MODE_LSB +: 3]);
                nxt_rxdLow = 1'b0;
                nxt_perCnt = 8'h00;
                nxt_cyclic = cfg_ff[`CFG_CYC_BIT];
                nxt_wdKeep = wrData[`WD_KEEP_BIT];
                nxt_wdOff  = 1'b0;
                if ((mode_ff == STOP && cyclic_ff) || wdOff_ff)
                    nxt_wdRestart = 1'b1;
            end
        end else begin
            case (mode_ff)
                SLEEP: begin
                    if (monChg || linRise) begin
                        nxt_mode = STANDBY;
                        nxt_wdRestart = ~wdKeep_ff;
                        if (linRise) begin
                            nxt_rxdLow = 1'b1;
                            nxt_doCnt  = `DO_PULSE_TICKS;
                        end
                    end else if (wdKeep_ff && pinSync_ff.wdExpire) begin
                        nxt_mode     = STANDBY;
                        nxt_resetReq = 1'b1;
                    end
                end
                STOP: begin
                    if (!wdKeep_ff && pinSync_ff.loadLow)
                        nxt_wdOff = 1'b1;
                    // no exit from Stop without a command
                    if (cyclic_ff) begin
                        if (tick) begin
                            if (perCnt_ff == cfg_ff[`CFG_PER_LSB +: 8]) begin
                                nxt_perCnt = 8'h00;
                                nxt_doCnt  = `DO_PULSE_TICKS;
                            end else
                                nxt_perCnt = 8'(perCnt_ff + 8'h01);
                        end
                        if (monChg || linRise)
                            nxt_doHold = 1'b1;
                        if (linRise)
                            nxt_rxdLow = 1'b1;
                    end else begin
                        if (monChg)
                            nxt_doCnt = `DO_PULSE_TICKS;
                        if (linRise) begin
                            nxt_rxdLow = 1'b1;
                            nxt_doCnt  = `DO_PULSE_TICKS;
                        end
                    end
                end
                default: ;
            endcase
        end
        nxt_regEn  = (nxt_mode != SLEEP);
        nxt_txEn   = (nxt_mode == ACTIVE);
        nxt_termEn = (nxt_mode == ACTIVE) || (nxt_mode == RX_ONLY);
        nxt_swEn   = (nxt_mode == ACTIVE) || (nxt_mode == ACT_LINOFF);
        nxt_oscEn  = (nxt_mode != SLEEP) || nxt_wdKeep;
        case (nxt_mode)
            SLEEP:   nxt_wdEn = nxt_wdKeep;
            STOP:    nxt_wdEn = nxt_wdKeep || !nxt_wdOff;
            default: nxt_wdEn = 1'b1;
        endcase
        nxt_rxd    = ~nxt_rxdLow;
        nxt_doLine = ~(nxt_doHold || nxt_doCnt != 2'h0);
    end
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            mode_ff      <= STANDBY;
            cyclic_ff    <= 1'b0;
            wdKeep_ff    <= 1'b0;
            wdOff_ff     <= 1'b0;
            rxdLow_ff    <= 1'b0;
            doHold_ff    <= 1'b0;
            doCnt_ff     <= 2'h0;
            perCnt_ff    <= 8'h00;
            regEn_ff     <= 1'b1;
            txEn_ff      <= 1'b0;
            termEn_ff    <= 1'b0;
            swEn_ff      <= 1'b0;
            oscEn_ff     <= 1'b1;
            wdEn_ff      <= 1'b1;
            wdRestart_ff <= 1'b0;
            resetReq_ff  <= 1'b0;
            rxd_ff       <= 1'b1;
            doLine_ff    <= 1'b1;
        end else begin
            mode_ff      <= nxt_mode;
            cyclic_ff    <= nxt_cyclic;
            wdKeep_ff    <= nxt_wdKeep;
            wdOff_ff     <= nxt_wdOff;
            rxdLow_ff    <= nxt_rxdLow;
            doHold_ff    <= nxt_doHold;
            doCnt_ff     <= nxt_doCnt;
            perCnt_ff    <= nxt_perCnt;
            regEn_ff     <= nxt_regEn;
            txEn_ff      <= nxt_txEn;
            termEn_ff    <= nxt_termEn;
            swEn_ff      <= nxt_swEn;
            oscEn_ff     <= nxt_oscEn;
            wdEn_ff      <= nxt_wdEn;
            wdRestart_ff <= nxt_wdRestart;
            resetReq_ff  <= nxt_resetReq;
            rxd_ff       <= nxt_rxd;
            doLine_ff    <= nxt_doLine;
        end
    end
    // Transmit dominant timeout; a stuck-low input must not jam the bus
    logic [11:0] txCnt_ff, nxt_txCnt;
    logic        txBlock_ff, nxt_txBlock;
    logic        linTxd_ff, nxt_linTxd;
    always_comb begin
        nxt_txCnt   = 12'h000;
        nxt_txBlock = txBlock_ff;
        if (!txBlock_ff) begin
            if (!pinSync_ff.txd) begin
                if (txCnt_ff >= 12'(`TXD_TO_CYC))
                    nxt_txBlock = 1'b1;
                else
                    nxt_txCnt = 12'(txCnt_ff + 12'h001);
            end
        end else if (pinSync_ff.txd) begin
            if (txCnt_ff >= 12'(`TXD_REC_CYC - 1))
                nxt_txBlock = 1'b0;
            else
                nxt_txCnt = 12'(txCnt_ff + 12'h001);
        end
        nxt_linTxd = nxt_txBlock || !txEn_ff || pinSync_ff.txd;
    end
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            txCnt_ff   <= 12'h000;
            txBlock_ff <= 1'b0;
            linTxd_ff  <= 1'b1;
        end else begin
            txCnt_ff   <= nxt_txCnt;
            txBlock_ff <= nxt_txBlock;
            linTxd_ff  <= nxt_linTxd;
        end
    end
    assign rdData              = rdData_ff;
    assign regulatorEn         = regEn_ff;
    assign linTxEn             = txEn_ff;
    assign linTermEn           = termEn_ff;
    assign switchEn            = swEn_ff;
    assign oscEn               = oscEn_ff;
    assign wdEn                = wdEn_ff;
    assign wdRestart           = wdRestart_ff;
    assign resetReq            = resetReq_ff;
    assign rxdLine             = rxd_ff;
    assign mcu_interrupt_input = doLine_ff;
    assign linTxd              = linTxd_ff;
    assign lowSlope            = lowSlope_ff;
    assign measSel             = measSel_ff;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);
    sequence s_sleepWake;
        mode_ff == SLEEP && !cmdValid && (monChg || linRise);
    endsequence
    sequence s_stopLinWake;
        mode_ff == STOP && !cyclic_ff && !cmdValid && linRise;
    endsequence
    property p_sleepOff;
        mode_ff == SLEEP |-> !regulatorEn && !linTxEn && !switchEn;
    endproperty
    a_sleepOff: assert property (p_sleepOff)
        else $error("Sleep left a supply or switch on");
    property p_sleepWake;
        s_sleepWake |=> mode_ff == STANDBY && regulatorEn;
    endproperty
    a_sleepWake: assert property (p_sleepWake)
        else $error("Wake from Sleep did not reach Standby");
    property p_wdExpire;
        mode_ff == SLEEP && wdKeep_ff && pinSync_ff.wdExpire && !monChg &&
        !linRise && !cmdValid |=> resetReq && mode_ff == STANDBY;
    endproperty
    a_wdExpire: assert property (p_wdExpire)
        else $error("Watchdog expiry in Sleep gave no reset");
    property p_sleepLin;
        mode_ff == SLEEP && !cmdValid && linRise
        |=> !rxdLine && !mcu_interrupt_input;
    endproperty
    a_sleepLin: assert property (p_sleepLin)
        else $error("LIN wake from Sleep did not pull lines low");
    property p_restart;
        s_sleepWake ##0 !wdKeep_ff |=> wdRestart;
    endproperty
    a_restart: assert property (p_restart)
        else $error("Watchdog not restarted after Sleep wake");
    property p_osc;
        mode_ff == SLEEP && wdKeep_ff |-> oscEn;
    endproperty
    a_osc: assert property (p_osc)
        else $error("Oscillator stopped with watchdog kept on");
    property p_stopPower;
        mode_ff == STOP |-> !linTxEn && !linTermEn && regulatorEn;
    endproperty
    a_stopPower: assert property (p_stopPower)
        else $error("Stop power state wrong");
    property p_stopLin;
        s_stopLinWake |=> !rxdLine && doCnt_ff == `DO_PULSE_TICKS;
    endproperty
    a_stopLin: assert property (p_stopLin)
        else $error("LIN wake in Stop gave wrong indication");
    property p_wdOff;
        mode_ff == STOP && !wdKeep_ff && pinSync_ff.loadLow && !cmdValid
        |=> !wdEn;
    endproperty
    a_wdOff: assert property (p_wdOff)
        else $error("Watchdog not disabled at low load");
    property p_cycHold;
        mode_ff == STOP && cyclic_ff && !cmdValid && monChg
        |=> !mcu_interrupt_input ##1 (!mcu_interrupt_input || $past(cmdValid));
    endproperty
    a_cycHold: assert property (p_cycHold)
        else $error("Cyclic wake did not hold data-out low");
    property p_txBlock;
        txBlock_ff |=> linTxd;
    endproperty
    a_txBlock: assert property (p_txBlock)
        else $error("Bus not recessive after dominant timeout");
    property p_activeWd;
        mode_ff == ACTIVE |-> wdEn;
    endproperty
    a_activeWd: assert property (p_activeWd)
        else $error("Watchdog off in Active");

endmodule : low_power_mode_wake_control

`default_nettype wire

//--- core/low_power_mode_wake_control_pkg.sv
package low_power_mode_wake_control_pkg;

    typedef enum logic [2:0] {
        STANDBY    = 3'h0,
        ACTIVE     = 3'h1,
        STOP       = 3'h3,
        SLEEP      = 3'h2,
        RX_ONLY    = 3'h6,
        ACT_LINOFF = 3'h7
    } mode_type;

    typedef struct packed {
        logic [3:0] monitor_wake_inputs;
        logic       linWake;
        logic       txd;
        logic       wdExpire;
        logic       loadLow;
        logic       oscClk;
    } pins_type;

endpackage : low_power_mode_wake_control_pkg

//--- core/low_power_mode_wake_control_regs.svh
`ifndef LOW_POWER_MODE_WAKE_CONTROL_REGS_SVH
`define LOW_POWER_MODE_WAKE_CONTROL_REGS_SVH

// Register word indices on the plain port
`define CTRL_OFS        2'h0
`define CFG_OFS         2'h1
`define STAT_OFS        2'h2

// Control word fields
`define MODE_LSB        0
`define WD_KEEP_BIT     15
`define CTRL_RST        16'h0000

// Mode select patterns
`define PAT_ACT_LINOFF  3'h2
`define PAT_ACTIVE      3'h3
`define PAT_SLEEP       3'h4
`define PAT_RX_ONLY     3'h6
`define PAT_STOP        3'h7

// Configuration word fields
`define CFG_PER_LSB     0
`define CFG_CYC_BIT     8
`define CFG_SLOPE_BIT   9
`define CFG_MEAS_BIT    10
`define CFG_RST         16'h0000

// Timing
`define DO_PULSE_TICKS  2'h2
`define SYS_CLK_NS      10
`define TXD_TO_NS       20000
`define TXD_REC_NS      10000
`define TXD_TO_CYC      ((`TXD_TO_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)
`define TXD_REC_CYC     ((`TXD_REC_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)

`endif

//--- verification/low_power_mode_wake_control_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "low_power_mode_wake_control_regs.svh"

module low_power_mode_wake_control_bench
    import low_power_mode_wake_control_pkg::*;
();
    logic        sys_clk, srst, wrStrobe, rdStrobe;
    logic [1:0]  addr;
    logic [15:0] wrData, rdData, lowLen, nPulse, nRestart, nReset, v, p;
    logic [3:0]  mon;
    logic        linWake, txd, wdExp, loadLow, osc;
    pins_type    pinBus;
    logic        regulatorEn, linTxEn, linTermEn, switchEn, oscEn, wdEn;
    logic        wdRestart, resetReq, rxdLine, doLine, linTxd;
    logic        lowSlope, measSel;
    logic [7:0]  outs;
    int          errors, nTests;

    assign pinBus = {mon, linWake, txd, wdExp, loadLow, osc};
    assign outs   = {regulatorEn, linTxEn, linTermEn, switchEn,
                     oscEn, wdEn, rxdLine, doLine};

    low_power_mode_wake_control i_low_power_mode_wake_control (
        .sys_clk, .srst, .addr, .wrData, .wrStrobe, .rdStrobe, .rdData,
        .pinIn(pinBus), .regulatorEn, .linTxEn, .linTermEn, .switchEn,
        .oscEn, .wdEn, .wdRestart, .resetReq, .rxdLine,
        .mcu_interrupt_input(doLine), .linTxd, .lowSlope, .measSel
    );

    mcu_wake_model i_mcu_wake_model (
        .sys_clk, .srst, .doLine, .wdRestart, .resetReq,
        .lowLen, .nPulse, .nRestart, .nReset
    );

    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        nTests++;
        if (s !== e) begin
            errors++;
            $display("CHECK FAILED %0t: got %h expected %h", $time, s, e);
        end
    endtask : chk

    task automatic end_sim();
        if (errors == 0 && nTests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : cyc

    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        addr     <= a;
        wrData   <= d;
        wrStrobe <= 1'b1;
        @(posedge sys_clk);
        wrStrobe <= 1'b0;
    endtask : wr

    task automatic rd(input logic [1:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        addr     <= a;
        rdStrobe <= 1'b1;
        @(posedge sys_clk);
        rdStrobe <= 1'b0;
        #1 d = rdData;
    endtask : rd

    task automatic chkMode(input mode_type m);
        logic [15:0] s;
        rd(`STAT_OFS, s);
        chk({13'h0, s[2:0]}, {13'h0, m});
    endtask : chkMode

    // Sampled 1 ns late so this edge's flop updates have landed
    task automatic chkO(input logic [7:0] m, input logic [7:0] e);
        #1 chk({8'h0, outs & m}, {8'h0, e});
    endtask : chkO

    task automatic chkIn(input logic [15:0] s, input logic [15:0] lo,
                         input logic [15:0] hi);
        chk({15'h0, s >= lo && s <= hi}, 16'h0001);
    endtask : chkIn

    task automatic waitPulse(input logic [15:0] q);
        for (int i = 0; i < 400 && nPulse === q; i++)
            @(posedge sys_clk);
        if (nPulse === q) begin
            errors++;
            $display("CHECK FAILED %0t: no data-out pulse", $time);
            end_sim();
        end
    endtask : waitPulse

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Oscillator free-running, phase unrelated to sys_clk
    initial begin
        osc = 1'b0;
        #37;
        forever #80 osc = ~osc;
    end

    initial begin
        errors   = 0;
        nTests   = 0;
        srst     = 1'b1;
        addr     = 2'h0;
        wrData   = 16'h0;
        wrStrobe = 1'b0;
        rdStrobe = 1'b0;
        mon      = 4'h0;
        linWake  = 1'b0;
        txd      = 1'b1;
        wdExp    = 1'b0;
        loadLow  = 1'b0;
        cyc(4);
        srst <= 1'b0;
        chkO(8'hff, 8'h8f);
        chkMode(STANDBY);
        rd(`CFG_OFS, v);
        chk(v, `CFG_RST);
        rd(2'h3, v);
        chk(v, 16'h0000);
        wr(`CTRL_OFS, 16'h0000);
        wr(`CTRL_OFS, 16'h0001);
        wr(`CTRL_OFS, 16'h0005);
        rd(`CTRL_OFS, v);
        chk(v, `CTRL_RST);
        chkMode(STANDBY);
        wr(`CTRL_OFS, {13'h0, `PAT_RX_ONLY});
        chkMode(RX_ONLY);
        wr(`CTRL_OFS, {13'h0, `PAT_ACT_LINOFF});
        chkMode(ACT_LINOFF);
        wr(`CTRL_OFS, {13'h0, `PAT_ACTIVE});
        cyc(2);
        chkO(8'hf7, 8'hf7);
        chkMode(ACTIVE);
        wr(`CFG_OFS, 16'h0600);
        cyc(2);
        chk({14'h0, lowSlope, measSel}, 16'h0003);
        wr(`CFG_OFS, 16'h0000);
        cyc(2);
        chk({14'h0, lowSlope, measSel}, 16'h0000);
        txd <= 1'b0;
        cyc(10);
        chk({15'h0, linTxd}, 16'h0000);
        cyc(2100);
        chk({15'h0, linTxd}, 16'h0001);
        txd <= 1'b1;
        cyc(500);
        txd <= 1'b0;
        cyc(10);
        chk({15'h0, linTxd}, 16'h0001);
        txd <= 1'b1;
        cyc(1100);
        txd <= 1'b0;
        cyc(10);
        chk({15'h0, linTxd}, 16'h0000);
        txd <= 1'b1;
        wr(`CTRL_OFS, {13'h0, `PAT_SLEEP});
        cyc(2);
        chkO(8'hd4, 8'h00);
        chkMode(SLEEP);
        p = nRestart;
        cyc(1);
        mon <= 4'h1;
        cyc(6);
        chkO(8'h80, 8'h80);
        chkMode(STANDBY);
        chk({15'h0, nRestart !== p}, 16'h0001);
        wr(`CTRL_OFS, {1'b1, 12'h0, `PAT_SLEEP});
        cyc(2);
        chkO(8'h8c, 8'h0c);
        p = nReset;
        cyc(1);
        wdExp <= 1'b1;
        cyc(6);
        wdExp <= 1'b0;
        chkMode(STANDBY);
        chk({15'h0, nReset !== p}, 16'h0001);
        wr(`CTRL_OFS, {13'h0, `PAT_SLEEP});
        cyc(2);
        linWake <= 1'b1;
        cyc(6);
        linWake <= 1'b0;
        chkO(8'h83, 8'h80);
        chkMode(STANDBY);
        cyc(60);
        chkO(8'h02, 8'h00);
        wr(`CTRL_OFS, {13'h0, `PAT_ACTIVE});
        cyc(2);
        chkO(8'h02, 8'h02);
        wr(`CTRL_OFS, {13'h0, `PAT_STOP});
        cyc(2);
        chkO(8'he0, 8'h80);
        chkMode(STOP);
        cyc(1);
        loadLow <= 1'b1;
        cyc(6);
        chkO(8'h04, 8'h00);
        p = nPulse;
        cyc(1);
        mon <= 4'h0;
        waitPulse(p);
        p = nPulse;
        linWake <= 1'b1;
        cyc(6);
        linWake <= 1'b0;
        chkO(8'h03, 8'h00);
        waitPulse(p);
        chkIn(lowLen, 16'h0010, 16'h0022);
        chkO(8'h02, 8'h00);
        chkMode(STOP);
        wr(`CTRL_OFS, {13'h0, `PAT_ACTIVE});
        cyc(2);
        loadLow <= 1'b0;
        chkO(8'h06, 8'h06);
        wr(`CTRL_OFS, {1'b1, 12'h0, `PAT_STOP});
        loadLow <= 1'b1;
        cyc(8);
        chkO(8'h04, 8'h04);
        wr(`CTRL_OFS, {13'h0, `PAT_ACTIVE});
        loadLow <= 1'b0;
        wr(`CFG_OFS, 16'h0103);
        wr(`CTRL_OFS, {13'h0, `PAT_STOP});
        p = nPulse;
        cyc(640);
        mon <= 4'h5;
        #1;
        chkIn(nPulse - p, 16'h0008, 16'h000a);
        chkIn(lowLen, 16'h0010, 16'h0022);
        cyc(200);
        chkO(8'h01, 8'h00);
        p = nRestart;
        wr(`CTRL_OFS, {13'h0, `PAT_ACTIVE});
        // A cyclic pulse already under way runs out its two ticks
        cyc(40);
        chkO(8'h03, 8'h03);
        chk({15'h0, nRestart !== p}, 16'h0001);
        end_sim();
    end
endmodule : low_power_mode_wake_control_bench

`default_nettype wire

//--- verification/mcu_wake_model.sv
`timescale 1ns/100ps
`default_nettype none

module mcu_wake_model (
    input  wire logic        sys_clk,
    input  wire logic        srst,
    input  wire logic        doLine,
    input  wire logic        wdRestart,
    input  wire logic        resetReq,
    output logic      [15:0] lowLen,
    output logic      [15:0] nPulse,
    output logic      [15:0] nRestart,
    output logic      [15:0] nReset
);
    logic [15:0] runLen;

    // Low time closes on the rising edge, so a held low is counted only once it ends
    always @(posedge sys_clk) begin
        if (srst) begin
            runLen   <= 16'h0;
            lowLen   <= 16'h0;
            nPulse   <= 16'h0;
            nRestart <= 16'h0;
            nReset   <= 16'h0;
        end else begin
            runLen <= doLine ? 16'h0 : runLen + 16'h1;
            if (doLine && runLen != 16'h0) begin
                lowLen <= runLen;
                nPulse <= nPulse + 16'h1;
            end
            if (wdRestart) begin
                nRestart <= nRestart + 16'h1;
            end
            if (resetReq) begin
                nReset <= nReset + 16'h1;
            end
        end
    end
endmodule : mcu_wake_model

`default_nettype wire
